// File: core/utev_pkg.sv
package utev_pkg;

  // Register byte offsets on the bus.
  localparam logic [11:0] OFF_RX_START = 12'h000;
  localparam logic [11:0] OFF_RX_STOP = 12'h004;
  localparam logic [11:0] OFF_TX_START = 12'h008;
  localparam logic [11:0] OFF_TX_STOP = 12'h00C;
  localparam logic [11:0] OFF_PAUSE = 12'h01C;
  localparam logic [11:0] OFF_EV_CTS = 12'h100;
  localparam logic [11:0] OFF_EV_NOT_CLEAR_TO_SEND_EVENT = 12'h104;
  localparam logic [11:0] OFF_EV_RXRDY = 12'h108;
  localparam logic [11:0] OFF_EV_TXDONE = 12'h11C;
  localparam logic [11:0] OFF_EV_FAULT = 12'h124;
  localparam logic [11:0] OFF_EV_RXTO = 12'h144;
  localparam logic [11:0] OFF_LINKS = 12'h200;
  localparam logic [11:0] OFF_IRQ_SET = 12'h304;
  localparam logic [11:0] OFF_IRQ_CLR = 12'h308;
  localparam logic [11:0] OFF_FAULT_CAUSE = 12'h480;
  localparam logic [11:0] OFF_ENABLE = 12'h500;
  localparam logic [11:0] OFF_PSEL_RTS = 12'h508;
  localparam logic [11:0] OFF_PSEL_TXD = 12'h50C;
  localparam logic [11:0] OFF_PSEL_CTS = 12'h510;
  localparam logic [11:0] OFF_PSEL_RXD = 12'h514;
  localparam logic [11:0] OFF_RX_DATA = 12'h518;
  localparam logic [11:0] OFF_TX_DATA = 12'h51C;
  localparam logic [11:0] OFF_BIT_RATE = 12'h524;
  localparam logic [11:0] OFF_LINE_CFG = 12'h56C;

  // Field positions.
  localparam int CFG_FLOW_BIT = 0;
  localparam int CFG_PARITY_BIT = 1;
  localparam int LINK_CTS_START_BIT = 0;
  localparam int LINK_NOT_CLEAR_TO_SEND_EVENT_STOP_BIT = 1;
  localparam int CAUSE_PARITY_BIT = 1;
  localparam int CAUSE_FRAMING_BIT = 2;

  // Reset values.
  localparam logic [31:0] PSEL_RST = 32'hFFFFFFFF;
  localparam logic [15:0] BIT_RATE_RST = 16'h0364;
  localparam logic [3:0] ENABLE_RST = 4'h0;
  localparam logic [1:0] CFG_RST = 2'h0;

  typedef enum logic [2:0] {
    SER_IDLE = 3'h0,
    SER_START = 3'h1,
    SER_DATA = 3'h2,
    SER_PARITY = 3'h3,
    SER_STOP = 3'h4
  } utev_ser_t;

  typedef struct packed {
    logic ack;
    logic waitreq;
    logic [31:0] rdata;
    logic rx_run;
    logic tx_run;
    logic [7:0] tx_hold;
    logic tx_full;
    logic [7:0] rx_hold;
    logic rx_full;
    logic ev_cts;
    logic ev_not_clear_to_send_event;
    logic ev_rxrdy;
    logic ev_txdone;
    logic ev_fault;
    logic ev_rxto;
    logic rxto_pend;
    logic [1:0] links;
    logic [5:0] irq_en;
    logic [2:0] cause;
    logic [3:0] enable;
    logic [31:0] psel_rts;
    logic [31:0] psel_txd;
    logic [31:0] psel_cts;
    logic [31:0] psel_rxd;
    logic [15:0] bit_rate;
    logic [1:0] cfg;
    logic rxd_m;
    logic rxd_s;
    logic cts_m;
    logic cts_s;
    logic cts_prev;
    utev_ser_t tx_st;
    logic [15:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_par;
    logic txd;
    utev_ser_t rx_st;
    logic [15:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_par;
    logic rts_n;
  } utev_state_t;

endpackage : utev_pkg

// File: core/utev_top.sv
// Behaviour
// R1 - Writing one to rx start trigger starts reception; reads zero.
// R2 - Writing one to rx stop trigger stops reception.
// R3 - Writing one to tx start/stop triggers begins or ends transmission.
// R4 - Clear-to-send event sets when the CTS input falls low.
// R5 - Not-clear-to-send event sets when the CTS input rises high.
// R6 - Rx ready event sets once a byte lands in rx data holding.
// R7 - Line config register holds parity and flow-control enable, read/write.
// R8 - Tx done event sets after each byte is fully shifted out.
// R9 - Pause halts both directions, finishing a tx byte; rx acts as stopped.
// R10 - Event flags stay set until software writes zero to them.
module utev_top
  import utev_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic nrst_in,
  // Avalon-MM slave.
  input wire logic [11:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Serial line.
  input wire logic rxd_in,
  input wire logic cts_n_in,
  output logic txd_out,
  output logic rts_n_out
);

  utev_state_t s_q;
  utev_state_t s_d;

  logic bus_wr;
  logic wbit;
  logic cts_fall;
  logic cts_rise;
  logic enabled;
  logic tx_tick;
  logic rx_tick;
  logic [1:0] cfg_wdata;

  assign bus_wr = s_q.ack && avs_write_in;
  assign wbit = avs_writedata_in[0];
  assign cfg_wdata = avs_writedata_in[1:0];
  assign cts_fall = s_q.cts_prev && !s_q.cts_s;
  assign cts_rise = !s_q.cts_prev && s_q.cts_s;
  assign enabled = s_q.enable != 4'h0;
  assign tx_tick = s_q.tx_cnt == 16'h0000;
  assign rx_tick = s_q.rx_cnt == 16'h0000;

  always_comb
  begin
    logic start_rx;
    logic stop_rx;
    logic start_tx;
    logic stop_tx;
    logic pause;
    logic req;
    logic flow;
    start_rx = 1'b0;
    stop_rx = 1'b0;
    start_tx = 1'b0;
    stop_tx = 1'b0;
    pause = 1'b0;
    req = 1'b0;
    flow = 1'b0;
    s_d = s_q;

    // Two-stage synchronisers for the line inputs.
    s_d.rxd_m = rxd_in;
    s_d.rxd_s = s_q.rxd_m;
    s_d.cts_m = cts_n_in;
    s_d.cts_s = s_q.cts_m;
    s_d.cts_prev = s_q.cts_s;
    flow = s_q.cfg[CFG_FLOW_BIT];

    // One wait cycle, then the answer with waitrequest low.
    req = (avs_read_in || avs_write_in) && !s_q.ack;
    s_d.ack = req;
    s_d.waitreq = !req;
    s_d.rdata = 32'h00000000;
    if (req && avs_read_in)
    begin
      case (avs_address_in)
        OFF_EV_CTS: s_d.rdata = {31'h00000000, s_q.ev_cts};
        OFF_EV_NOT_CLEAR_TO_SEND_EVENT: s_d.rdata = {31'h00000000, s_q.ev_not_clear_to_send_event};
        OFF_EV_RXRDY: s_d.rdata = {31'h00000000, s_q.ev_rxrdy};
        OFF_EV_TXDONE: s_d.rdata = {31'h00000000, s_q.ev_txdone};
        OFF_EV_FAULT: s_d.rdata = {31'h00000000, s_q.ev_fault};
        OFF_EV_RXTO: s_d.rdata = {31'h00000000, s_q.ev_rxto};
        OFF_LINKS: s_d.rdata = {30'h00000000, s_q.links};
        OFF_IRQ_SET: s_d.rdata = {26'h0000000, s_q.irq_en};
        OFF_IRQ_CLR: s_d.rdata = {26'h0000000, s_q.irq_en};
        OFF_FAULT_CAUSE: s_d.rdata = {29'h00000000, s_q.cause};
        OFF_ENABLE: s_d.rdata = {28'h0000000, s_q.enable};
        OFF_PSEL_RTS: s_d.rdata = s_q.psel_rts;
        OFF_PSEL_TXD: s_d.rdata = s_q.psel_txd;
        OFF_PSEL_CTS: s_d.rdata = s_q.psel_cts;
        OFF_PSEL_RXD: s_d.rdata = s_q.psel_rxd;
        OFF_RX_DATA: s_d.rdata = {24'h000000, s_q.rx_hold};
        OFF_BIT_RATE: s_d.rdata = {16'h0000, s_q.bit_rate};
        OFF_LINE_CFG: s_d.rdata = {30'h00000000, s_q.cfg};
        default: s_d.rdata = 32'h00000000;
      endcase
    end

    // Reading the rx data holding register empties it.
    if (s_q.ack && avs_read_in && avs_address_in == OFF_RX_DATA)
    begin
      s_d.rx_full = 1'b0;
    end

    // Trigger decode, with the CTS shortcuts.
    if (bus_wr && wbit)
    begin
      start_rx = avs_address_in == OFF_RX_START;
      stop_rx = avs_address_in == OFF_RX_STOP;
      start_tx = avs_address_in == OFF_TX_START;
      stop_tx = avs_address_in == OFF_TX_STOP;
      pause = avs_address_in == OFF_PAUSE;
    end
    if (cts_fall && s_q.links[LINK_CTS_START_BIT])
    begin
      start_rx = 1'b1;
    end
    if (cts_rise && s_q.links[LINK_NOT_CLEAR_TO_SEND_EVENT_STOP_BIT])
    begin
      stop_rx = 1'b1;
    end

    // Event flags are cleared by writing zero; hardware sets further down win.
    // R10 zero write clears
    if (bus_wr && !wbit)
    begin
      case (avs_address_in)
        OFF_EV_CTS: s_d.ev_cts = 1'b0;
        OFF_EV_NOT_CLEAR_TO_SEND_EVENT: s_d.ev_not_clear_to_send_event = 1'b0;
        OFF_EV_RXRDY: s_d.ev_rxrdy = 1'b0;
        OFF_EV_TXDONE: s_d.ev_txdone = 1'b0;
        OFF_EV_FAULT: s_d.ev_fault = 1'b0;
        OFF_EV_RXTO: s_d.ev_rxto = 1'b0;
        default: s_d.ev_cts = s_q.ev_cts;
      endcase
    end

    // Plain register writes.
    if (bus_wr)
    begin
      case (avs_address_in)
        OFF_LINKS: s_d.links = avs_writedata_in[1:0];
        OFF_IRQ_SET: s_d.irq_en = s_q.irq_en | avs_writedata_in[5:0];
        OFF_IRQ_CLR: s_d.irq_en = s_q.irq_en & ~avs_writedata_in[5:0];
        OFF_FAULT_CAUSE: s_d.cause = s_q.cause & ~avs_writedata_in[2:0];
        OFF_ENABLE: s_d.enable = avs_writedata_in[3:0];
        OFF_PSEL_RTS: s_d.psel_rts = avs_writedata_in;
        OFF_PSEL_TXD: s_d.psel_txd = avs_writedata_in;
        OFF_PSEL_CTS: s_d.psel_cts = avs_writedata_in;
        OFF_PSEL_RXD: s_d.psel_rxd = avs_writedata_in;
        OFF_BIT_RATE: s_d.bit_rate = avs_writedata_in[15:0];
        // R7 config storage
        OFF_LINE_CFG: s_d.cfg = cfg_wdata;
        OFF_TX_DATA:
        begin
          s_d.tx_hold = avs_writedata_in[7:0];
          s_d.tx_full = 1'b1;
        end
        default: s_d.links = s_q.links;
      endcase
    end

    // R4 CTS falling edge
    if (cts_fall)
    begin
      s_d.ev_cts = 1'b1;
    end
    // R5 CTS rising edge
    if (cts_rise)
    begin
      s_d.ev_not_clear_to_send_event = 1'b1;
    end

    // R1 receiver start
    if (start_rx)
    begin
      s_d.rx_run = 1'b1;
      s_d.rxto_pend = 1'b0;
    end
    // R2 receiver stop
    // R9 pause stops receiver
    if (stop_rx || pause)
    begin
      s_d.rx_run = 1'b0;
      s_d.rxto_pend = 1'b1;
    end
    // R3 transmitter start
    if (start_tx)
    begin
      s_d.tx_run = 1'b1;
    end
    // R9 pause lets byte finish
    if (pause)
    begin
      s_d.tx_run = 1'b0;
    end

    // Transmit shifter; a byte in flight completes on pause.
    s_d.tx_cnt = tx_tick ? s_q.bit_rate - 16'h0001 : s_q.tx_cnt - 16'h0001;
    unique case (s_q.tx_st)
      SER_IDLE:
      begin
        s_d.txd = 1'b1;
        if (s_q.tx_run && s_q.tx_full && enabled && !(flow && s_q.cts_s))
        begin
          s_d.tx_sh = s_q.tx_hold;
          s_d.tx_par = ^s_q.tx_hold;
          // A byte written in this very cycle keeps the holding register full.
          s_d.tx_full = bus_wr && avs_address_in == OFF_TX_DATA;
          s_d.txd = 1'b0;
          s_d.tx_cnt = s_q.bit_rate - 16'h0001;
          s_d.tx_st = SER_START;
        end
      end
      SER_START:
      begin
        if (tx_tick)
        begin
          s_d.txd = s_q.tx_sh[0];
          s_d.tx_bit = 3'h0;
          s_d.tx_st = SER_DATA;
        end
      end
      SER_DATA:
      begin
        if (tx_tick)
        begin
          if (s_q.tx_bit == 3'h7)
          begin
            s_d.txd = s_q.cfg[CFG_PARITY_BIT] ? s_q.tx_par : 1'b1;
            s_d.tx_st = s_q.cfg[CFG_PARITY_BIT] ? SER_PARITY : SER_STOP;
          end
          else
          begin
            s_d.tx_sh = {1'b0, s_q.tx_sh[7:1]};
            s_d.txd = s_q.tx_sh[1];
            s_d.tx_bit = s_q.tx_bit + 3'h1;
          end
        end
      end
      SER_PARITY:
      begin
        if (tx_tick)
        begin
          s_d.txd = 1'b1;
          s_d.tx_st = SER_STOP;
        end
      end
      SER_STOP:
      begin
        // R8 byte shifted out
        if (tx_tick)
        begin
          s_d.ev_txdone = 1'b1;
          s_d.tx_st = SER_IDLE;
        end
      end
      default:
      begin
        s_d.txd = 1'b1;
        s_d.tx_st = SER_IDLE;
      end
    endcase
    // R3 transmitter stop
    if (stop_tx)
    begin
      s_d.tx_run = 1'b0;
      s_d.txd = 1'b1;
      s_d.tx_st = SER_IDLE;
    end

    // Receive sampler; a frame already started is finished unless its start bit reads high at mid-bit, which returns to idle.
    s_d.rx_cnt = rx_tick ? s_q.bit_rate - 16'h0001 : s_q.rx_cnt - 16'h0001;
    unique case (s_q.rx_st)
      SER_IDLE:
      begin
        if (s_q.rx_run && enabled && !s_q.rxd_s)
        begin
          s_d.rx_cnt = {1'b0, s_q.bit_rate[15:1]};
          s_d.rx_st = SER_START;
        end
        else if (s_q.rxto_pend)
        begin
          s_d.rxto_pend = 1'b0;
          s_d.ev_rxto = 1'b1;
        end
      end
      SER_START:
      begin
        if (rx_tick)
        begin
          s_d.rx_bit = 3'h0;
          s_d.rx_st = s_q.rxd_s ? SER_IDLE : SER_DATA;
        end
      end
      SER_DATA:
      begin
        if (rx_tick)
        begin
          s_d.rx_sh = {s_q.rxd_s, s_q.rx_sh[7:1]};
          s_d.rx_bit = s_q.rx_bit + 3'h1;
          if (s_q.rx_bit == 3'h7)
          begin
            s_d.rx_st = s_q.cfg[CFG_PARITY_BIT] ? SER_PARITY : SER_STOP;
          end
        end
      end
      SER_PARITY:
      begin
        if (rx_tick)
        begin
          s_d.rx_par = s_q.rxd_s;
          s_d.rx_st = SER_STOP;
        end
      end
      SER_STOP:
      begin
        if (rx_tick)
        begin
          s_d.rx_st = SER_IDLE;
          if (!s_q.rxd_s)
          begin
            s_d.ev_fault = 1'b1;
            s_d.cause[CAUSE_FRAMING_BIT] = 1'b1;
          end
          else if (s_q.cfg[CFG_PARITY_BIT] && (s_q.rx_par != ^s_q.rx_sh))
          begin
            s_d.ev_fault = 1'b1;
            s_d.cause[CAUSE_PARITY_BIT] = 1'b1;
          end
          else
          begin
            // R6 byte to holding
            s_d.rx_hold = s_q.rx_sh;
            s_d.rx_full = 1'b1;
            s_d.ev_rxrdy = 1'b1;
          end
        end
      end
      default:
      begin
        s_d.rx_st = SER_IDLE;
      end
    endcase

    // RTS is held active without flow control.
    s_d.rts_n = flow && !(s_q.rx_run && enabled && !s_d.rx_full);
  end

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      s_q <= '0;
      s_q.waitreq <= 1'b1;
      s_q.enable <= ENABLE_RST;
      s_q.psel_rts <= PSEL_RST;
      s_q.psel_txd <= PSEL_RST;
      s_q.psel_cts <= PSEL_RST;
      s_q.psel_rxd <= PSEL_RST;
      s_q.bit_rate <= BIT_RATE_RST;
      s_q.cfg <= CFG_RST;
      s_q.rxd_m <= 1'b1;
      s_q.rxd_s <= 1'b1;
      s_q.cts_m <= 1'b1;
      s_q.cts_s <= 1'b1;
      s_q.cts_prev <= 1'b1;
      s_q.tx_st <= SER_IDLE;
      s_q.rx_st <= SER_IDLE;
      s_q.txd <= 1'b1;
      s_q.rts_n <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign avs_readdata_out = s_q.rdata;
  assign avs_waitrequest_out = s_q.waitreq;
  assign txd_out = s_q.txd;
  assign rts_n_out = s_q.rts_n;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);

  // R1 start trigger check
  rx_start_a: assert property ( // R1
    bus_wr && wbit && avs_address_in == OFF_RX_START |=> s_q.rx_run && !s_q.rxto_pend)
    else $error("rx start trigger did not start the receiver");

  // R2 stop trigger check
  rx_stop_a: assert property ( // R2
    bus_wr && wbit && avs_address_in == OFF_RX_STOP |=> !s_q.rx_run ##1 s_q.rts_n || !s_q.cfg[0])
    else $error("rx stop trigger did not stop the receiver");

  // R3 stop trigger check
  tx_stop_a: assert property ( // R3
    bus_wr && wbit && avs_address_in == OFF_TX_STOP |=> s_q.tx_st == SER_IDLE && txd_out)
    else $error("tx stop trigger did not idle the line");

  // R4 CTS event check
  cts_event_a: assert property ( // R4
    $fell(s_q.cts_s) |=> s_q.ev_cts)
    else $error("clear-to-send event missed");

  // R5 NOT_CLEAR_TO_SEND_EVENT event check
  not_clear_to_send_event_event_a: assert property ( // R5
    $rose(s_q.cts_s) |=> s_q.ev_not_clear_to_send_event)
    else $error("not-clear-to-send event missed");

  // R6 ready event check
  rx_ready_a: assert property ( // R6
    $changed(s_q.rx_hold) |-> s_q.ev_rxrdy && s_q.rx_full)
    else $error("rx data placed without ready event");

  // R7 config readback
  line_cfg_a: assert property ( // R7
    bus_wr && avs_address_in == OFF_LINE_CFG |=> s_q.cfg == $past(cfg_wdata))
    else $error("line config did not store the written value");

  // R8 done event check
  tx_done_a: assert property ( // R8
    s_q.tx_st == SER_STOP && tx_tick |=> s_q.ev_txdone && s_q.tx_st == SER_IDLE)
    else $error("tx done event missed after stop bit");

  // R9 pause check
  pause_both_a: assert property ( // R9
    bus_wr && wbit && avs_address_in == OFF_PAUSE
    && (s_q.tx_st == SER_START || s_q.tx_st == SER_DATA)
    |=> !s_q.tx_run && !s_q.rx_run && s_q.tx_st != SER_IDLE)
    else $error("pause did not halt both directions gracefully");

  // R10 sticky flag check
  event_hold_a: assert property ( // R10
    s_q.ev_cts && !(bus_wr && !wbit && avs_address_in == OFF_EV_CTS) |=> s_q.ev_cts)
    else $error("event flag dropped without a zero write");

endmodule // utev_top

// File: verif/utev_peer.sv
// Counterpart serial device: sends frames to the block and collects the frames it sends.
module utev_peer
  #(parameter int BIT_CYC = 8)
(
  // Clock.
  input wire logic clk_in,
  // Lines from the block, plus the parity enable from the bench.
  input wire logic txd_in,
  input wire logic rts_n_in,
  input wire logic par_en_in,
  // Lines to the block.
  output logic rxd_out,
  output logic cts_n_out
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] got_byte;
  logic [7:0] sh;
  logic got_par_ok;
  int got_cnt;

  initial
  begin
    rxd_out = 1'b1;
    cts_n_out = 1'b0;
    got_byte = 8'h00;
    got_par_ok = 1'b0;
    got_cnt = 0;
  end

  // Each bit is sampled in its middle; the byte counts once the stop bit is reached.
  initial
  forever
  begin
    @(negedge txd_in);
    repeat (BIT_CYC / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CYC) @(posedge clk_in);
      sh[i] = txd_in;
    end
    got_par_ok = 1'b1;
    if (par_en_in)
    begin
      repeat (BIT_CYC) @(posedge clk_in);
      got_par_ok = (txd_in === ^sh);
    end
    repeat (BIT_CYC) @(posedge clk_in);
    got_byte = sh;
    got_cnt++;
  end

  // Sends one frame once the block requests it; bad_par inverts the parity bit on purpose.
  task automatic send_byte(input logic [7:0] b, input logic bad_par);
    @(posedge clk_in);
    while (rts_n_in !== 1'b0)
      @(posedge clk_in);
    rxd_out <= 1'b0;
    repeat (BIT_CYC) @(posedge clk_in);
    for (int i = 0; i < 8; i++)
    begin
      rxd_out <= b[i];
      repeat (BIT_CYC) @(posedge clk_in);
    end
    if (par_en_in)
    begin
      rxd_out <= ^b ^ bad_par;
      repeat (BIT_CYC) @(posedge clk_in);
    end
    rxd_out <= 1'b1;
    repeat (2 * BIT_CYC) @(posedge clk_in);
  endtask

  task automatic set_cts(input logic v);
    @(posedge clk_in);
    cts_n_out <= v;
  endtask
endmodule // utev_peer

// File: verif/test_uart_task_event_registers.sv
`define UTEV_CHK(got, want) \
  begin \
    cmp_count++; \
    if ((got) !== (want)) \
    begin \
      n_mismatch++; \
      $display("wrong value at %0t: got %h expected %h", $time, (got), (want)); \
    end \
  end

module test_uart_task_event_registers
  import utev_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int BIT_CYC = 8;
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] exp_v;
  } utev_row_t;
  localparam utev_row_t ROWS[13] = '{
    '{OFF_LINE_CFG, 32'hFFFFFFFF, 32'h00000003},
    '{OFF_LINE_CFG, 32'h00000000, 32'h00000000},
    '{OFF_RX_START, 32'h00000001, 32'h00000000},
    '{OFF_RX_STOP, 32'h00000001, 32'h00000000},
    '{OFF_TX_START, 32'h00000001, 32'h00000000},
    '{OFF_TX_STOP, 32'h00000001, 32'h00000000},
    '{OFF_PAUSE, 32'h00000001, 32'h00000000},
    '{OFF_EV_RXRDY, 32'h00000001, 32'h00000000},
    '{OFF_BIT_RATE, BIT_CYC, BIT_CYC},
    '{OFF_ENABLE, 32'h00000001, 32'h00000001},
    '{12'h7F0, 32'h00000001, 32'h00000000},
    '{OFF_IRQ_SET, 32'h00000005, 32'h00000005},
    '{OFF_IRQ_CLR, 32'h00000001, 32'h00000004}};
  localparam utev_row_t RST_ROWS[6] = '{
    '{OFF_LINE_CFG, 32'h0, 32'h00000000},
    '{OFF_BIT_RATE, 32'h0, {16'h0000, BIT_RATE_RST}},
    '{OFF_PSEL_TXD, 32'h0, PSEL_RST},
    '{OFF_ENABLE, 32'h0, 32'h00000000},
    '{OFF_EV_TXDONE, 32'h0, 32'h00000000},
    '{OFF_EV_RXRDY, 32'h0, 32'h00000000}};
  localparam logic [11:0] HALTS[2] = '{OFF_TX_STOP, OFF_PAUSE};

  logic mclk_in, nrst_in, avs_read_in, avs_write_in, peer_par;
  logic [11:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, rd;
  logic avs_waitrequest_out, txd_out, rts_n_out, rxd, cts_n;
  int n_mismatch, cmp_count, base;

  utev_top dut_u (.mclk_in(mclk_in), .nrst_in(nrst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .rxd_in(rxd), .cts_n_in(cts_n), .txd_out(txd_out), .rts_n_out(rts_n_out));
  utev_peer #(.BIT_CYC(BIT_CYC)) peer_u (.clk_in(mclk_in), .txd_in(txd_out),
    .rts_n_in(rts_n_out), .par_en_in(peer_par), .rxd_out(rxd), .cts_n_out(cts_n));

  initial
  begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  // Holds one request until the edge that sees waitrequest low, then releases it.
  task automatic bus_req(input logic [11:0] a, input logic wr, input logic [31:0] d);
    @(posedge mclk_in);
    avs_address_in <= a;
    avs_write_in <= wr;
    avs_read_in <= ~wr;
    avs_writedata_in <= d;
    do
    begin
      @(posedge mclk_in);
    end
    while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus_req(a, 1'b1, d);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] want);
    bus_req(a, 1'b0, 32'h00000000);
    `UTEV_CHK(rd, want)
  endtask

  // Waits for the peer to collect a byte, then lets the stop bit run out.
  task automatic wait_byte(input int target);
    while (peer_u.got_cnt < target)
    begin
      @(posedge mclk_in);
    end
    repeat (BIT_CYC) @(posedge mclk_in);
  endtask

  task automatic test_end(input string s);
    $display("test %s finished, mismatches so far %0d", s, n_mismatch);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (10000) @(posedge mclk_in);
    n_mismatch++;
    wrap_up();
  end

  initial
  begin
    n_mismatch = 0;
    cmp_count = 0;
    nrst_in = 1'b0;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_address_in = 12'h000;
    avs_writedata_in = 32'h00000000;
    peer_par = 1'b0;
    repeat (20) @(posedge mclk_in);
    nrst_in <= 1'b1;
    foreach (ROWS[i])
    begin
      wr(ROWS[i].addr, ROWS[i].wdata);
      rd_chk(ROWS[i].addr, ROWS[i].exp_v);
    end
    test_end("register table");

    wr(OFF_LINE_CFG, 32'h00000002);
    peer_par <= 1'b1;
    wr(OFF_TX_START, 32'h00000001);
    base = peer_u.got_cnt;
    wr(OFF_TX_DATA, 32'h000000A5);
    wait_byte(base + 1);
    `UTEV_CHK(peer_u.got_byte, 8'hA5)
    `UTEV_CHK(peer_u.got_par_ok, 1'b1)
    rd_chk(OFF_EV_TXDONE, 32'h00000001);
    wr(OFF_EV_TXDONE, 32'h00000001);
    rd_chk(OFF_EV_TXDONE, 32'h00000001);
    wr(OFF_EV_TXDONE, 32'h00000000);
    rd_chk(OFF_EV_TXDONE, 32'h00000000);
    test_end("transmit with parity");

    wr(OFF_RX_START, 32'h00000001);
    peer_u.send_byte(8'h5A, 1'b0);
    rd_chk(OFF_EV_RXRDY, 32'h00000001);
    rd_chk(OFF_RX_DATA, 32'h0000005A);
    wr(OFF_EV_RXRDY, 32'h00000000);
    peer_u.send_byte(8'h33, 1'b1);
    rd_chk(OFF_EV_RXRDY, 32'h00000000);
    rd_chk(OFF_EV_FAULT, 32'h00000001);
    rd_chk(OFF_FAULT_CAUSE, 32'h00000002);
    wr(OFF_EV_RXTO, 32'h00000000);
    wr(OFF_RX_STOP, 32'h00000001);
    peer_u.send_byte(8'h11, 1'b0);
    rd_chk(OFF_EV_RXRDY, 32'h00000000);
    rd_chk(OFF_EV_RXTO, 32'h00000001);
    test_end("receive and stop");

    wr(OFF_EV_CTS, 32'h00000000);
    wr(OFF_EV_NOT_CLEAR_TO_SEND_EVENT, 32'h00000000);
    peer_u.set_cts(1'b1);
    repeat (8) @(posedge mclk_in);
    rd_chk(OFF_EV_NOT_CLEAR_TO_SEND_EVENT, 32'h00000001);
    rd_chk(OFF_EV_CTS, 32'h00000000);
    peer_u.set_cts(1'b0);
    repeat (8) @(posedge mclk_in);
    rd_chk(OFF_EV_CTS, 32'h00000001);
    test_end("clear to send events");

    wr(OFF_LINE_CFG, 32'h00000000);
    peer_par <= 1'b0;
    wr(OFF_TX_START, 32'h00000001);
    base = peer_u.got_cnt;
    wr(OFF_TX_DATA, 32'h00000096);
    wr(OFF_PAUSE, 32'h00000001);
    wait_byte(base + 1);
    `UTEV_CHK(peer_u.got_byte, 8'h96)
    foreach (HALTS[k])
    begin
      wr(HALTS[k], 32'h00000001);
      base = peer_u.got_cnt;
      wr(OFF_TX_DATA, 32'h00000040 + k);
      repeat (15 * BIT_CYC) @(posedge mclk_in);
      `UTEV_CHK(peer_u.got_cnt, base)
      wr(OFF_TX_START, 32'h00000001);
      wait_byte(base + 1);
      `UTEV_CHK(peer_u.got_byte, 8'h40 + k)
    end
    test_end("halt and resume");

    wr(OFF_LINE_CFG, 32'h00000001);
    wr(OFF_RX_START, 32'h00000001);
    repeat (2) @(posedge mclk_in);
    `UTEV_CHK(rts_n_out, 1'b0)
    peer_u.set_cts(1'b1);
    base = peer_u.got_cnt;
    wr(OFF_TX_DATA, 32'h0000003C);
    repeat (15 * BIT_CYC) @(posedge mclk_in);
    `UTEV_CHK(peer_u.got_cnt, base)
    peer_u.set_cts(1'b0);
    wait_byte(base + 1);
    `UTEV_CHK(peer_u.got_byte, 8'h3C)
    wr(OFF_RX_STOP, 32'h00000001);
    repeat (2) @(posedge mclk_in);
    `UTEV_CHK(rts_n_out, 1'b1)
    test_end("flow control");

    @(posedge mclk_in);
    nrst_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    `UTEV_CHK(txd_out, 1'b1)
    `UTEV_CHK(rts_n_out, 1'b1)
    nrst_in <= 1'b1;
    foreach (RST_ROWS[i])
      rd_chk(RST_ROWS[i].addr, RST_ROWS[i].exp_v);
    test_end("reset in mid run");
    wrap_up();
  end
endmodule // test_uart_task_event_registers
